// ### scpm_pkg.sv
// scpm_pkg: constants of the system clock and power mode controller.
// assumes one 250 MHz core clock that models both RC oscillators as tick enables.
package scpm_pkg;
  // core clock rate and oscillator rates
  localparam int CLK_HZ    = 250_000_000;
  localparam int FAST2_HZ  = 2_000_000;
  localparam int FAST4_HZ  = 4_000_000;
  localparam int FAST8_HZ  = 8_000_000;
  localparam int SLOW_HZ   = 32_000;
  // oscillator periods in core cycles, rounded down
  localparam int PER_W          = 13;
  localparam int FAST2_CYC      = CLK_HZ / FAST2_HZ;
  localparam int FAST4_CYC      = CLK_HZ / FAST4_HZ;
  localparam int FAST8_CYC      = CLK_HZ / FAST8_HZ;
  localparam int SLOW_PERIOD_CYC = CLK_HZ / SLOW_HZ;
  // fast oscillator settling time in core cycles, arbitrary plain default
  localparam int FAST_STARTUP_CYC = 64;
  localparam int STARTUP_W        = 16;
  // register port
  localparam int       ADDR_W            = 4;
  localparam logic [3:0] OFF_SYS_CLK_CTRL  = 4'h0;
  localparam logic [3:0] OFF_FAST_OSC_CTRL = 4'h4;
  localparam logic [3:0] OFF_MODE_STATUS   = 4'h8;
  // field positions
  localparam int SEL_LSB   = 5;
  localparam int FKEEP_BIT = 1;
  localparam int SKEEP_BIT = 0;
  localparam int FREQ_LSB  = 2;
  localparam int STBL_BIT  = 1;
  localparam int FEN_BIT   = 0;
  // clock select codes and reset values
  localparam logic [2:0] SEL_FAST   = 3'h0;
  localparam logic [2:0] SEL_SUB    = 3'h7;
  localparam logic [1:0] FREQ_2M    = 2'h0;
  localparam logic [1:0] FREQ_4M    = 2'h1;
  localparam logic [1:0] FREQ_8M    = 2'h2;
  localparam logic [1:0] FREQ_RST   = 2'h0;
  localparam logic       FEN_RST    = 1'b1;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    M_FAST  = 6'h01,
    M_SLOW  = 6'h02,
    M_SLEEP = 6'h04,
    M_IDLE0 = 6'h08,
    M_IDLE1 = 6'h10,
    M_IDLE2 = 6'h20
  } scpm_mode_t;
endpackage

// ### scpm_tick_gen.sv
// scpm_tick_gen: models a free running oscillator as a one-cycle tick.
// assumes period is at least one and is held steady while run is high.
module scpm_tick_gen #(
  parameter int W = 13
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // output
  output logic              tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  // count core cycles, emit a tick per oscillator period
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt >= period - W'(1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  // register counter and tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ### scpm_top.sv
// scpm_top: system clock selection, fast oscillator control and operating modes.
// assumes a cpu that pulses HALT and WAKE, and software on a plain register port.
// Behaviour
// - software changes the system clock source at run time without reset
// - slow oscillator also clocks the watchdog and the time base
// - fast mode uses fast oscillator divided by 1 to 64
// - slow mode runs the cpu from the sub clock of the slow oscillator
// - after moving to sub clock the fast oscillator follows its enable bit
// - six modes: fast, slow, sleep, idle0, idle1, idle2
// - halt with both keep bits zero enters sleep, sub clock stops
// - slow oscillator keeps running in sleep for the watchdog
// - halt with fast keep 0 and slow keep 1 enters idle0
// - halt with both keep bits one enters idle1
// - halt with fast keep 1 and slow keep 0 enters idle2
// - select 000 undivided, 001-110 divided 2 to 64, 111 sub clock
// - frequency field decode, new frequency applies when stable flag sets
// - enabling fast oscillator clears stable flag, sets it once settled
//
// Added by the designer: the placing of the registers and the plain strobed port.
module scpm_top #(
  parameter int SLOW_PERIOD  = scpm_pkg::SLOW_PERIOD_CYC,
  parameter int FAST_STARTUP = scpm_pkg::FAST_STARTUP_CYC
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  // register port
  input  wire logic [scpm_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [7:0]                  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [7:0]                  RDATA,
  // cpu handshake
  input  wire logic                        HALT,
  input  wire logic                        WAKE,
  // clock enables and status
  output logic                             SYS_CLK_EN,
  output logic                             FAST_CLK_EN,
  output logic                             SUB_CLK_EN,
  output logic                             SLOW_RC_CLK_EN,
  output logic                             CPU_RUN,
  output logic                             FAST_OSC_ON
);
  localparam int PW = scpm_pkg::PER_W;
  localparam int SW = scpm_pkg::STARTUP_W;

  // assertion clock and reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // software visible control
  logic [2:0] sys_clk_select;
  logic       fast_osc_keep_in_halt;
  logic       slow_osc_keep_in_halt;
  logic [1:0] fast_osc_freq_select;
  logic       fast_osc_enable;
  logic [2:0] next_sel;
  logic       next_fkeep;
  logic       next_skeep;
  logic [1:0] next_freq;
  logic       next_fen;
  logic [7:0] next_rdata;
  // fast oscillator state
  logic          fast_run;
  logic          fast_osc_stable_flag;
  logic [SW-1:0] scnt;
  logic [1:0]    act_freq;
  logic          next_stable;
  logic [SW-1:0] next_scnt;
  logic [1:0]    next_act_freq;
  logic          fast_tick;
  logic          slow_tick;
  // clock switch state
  logic [2:0] active_sel;
  logic [5:0] div_cnt;
  logic [2:0] next_active_sel;
  logic [5:0] next_div_cnt;
  logic       div_tick;
  logic       cur_tick;
  logic       swap;
  // mode state
  scpm_pkg::scpm_mode_t mode;
  scpm_pkg::scpm_mode_t next_mode;
  logic cpu_run;
  logic next_sys_en;
  logic next_sub_en;

  // fast oscillator period per frequency code
  function automatic logic [PW-1:0] fast_period(input logic [1:0] f);
    unique case (f)
      scpm_pkg::FREQ_4M: fast_period = PW'(scpm_pkg::FAST4_CYC);
      scpm_pkg::FREQ_8M: fast_period = PW'(scpm_pkg::FAST8_CYC);
      default:           fast_period = PW'(scpm_pkg::FAST2_CYC);
    endcase
  endfunction

  // divider mask: 2^sel - 1, one system tick per 2^sel fast ticks
  function automatic logic [5:0] div_mask(input logic [2:0] s);
    div_mask = 6'((7'h01 << s) - 7'h01);
  endfunction

  // register writes and read decode
  always_comb begin
    next_sel   = sys_clk_select;
    next_fkeep = fast_osc_keep_in_halt;
    next_skeep = slow_osc_keep_in_halt;
    next_freq  = fast_osc_freq_select;
    next_fen   = fast_osc_enable;
    next_rdata = 8'h00;
    if (WR && ADDR == scpm_pkg::OFF_SYS_CLK_CTRL) begin
      next_sel   = WDATA[scpm_pkg::SEL_LSB +: 3];
      next_fkeep = WDATA[scpm_pkg::FKEEP_BIT];
      next_skeep = WDATA[scpm_pkg::SKEEP_BIT];
    end
    if (WR && ADDR == scpm_pkg::OFF_FAST_OSC_CTRL) begin
      next_freq = WDATA[scpm_pkg::FREQ_LSB +: 2];
      next_fen  = WDATA[scpm_pkg::FEN_BIT];
    end
    if (RD) begin
      unique case (ADDR)
        scpm_pkg::OFF_SYS_CLK_CTRL: begin
          next_rdata[scpm_pkg::SEL_LSB +: 3]   = sys_clk_select;
          next_rdata[scpm_pkg::FKEEP_BIT]      = fast_osc_keep_in_halt;
          next_rdata[scpm_pkg::SKEEP_BIT]      = slow_osc_keep_in_halt;
        end
        scpm_pkg::OFF_FAST_OSC_CTRL: begin
          next_rdata[scpm_pkg::FREQ_LSB +: 2]  = fast_osc_freq_select;
          next_rdata[scpm_pkg::STBL_BIT]       = fast_osc_stable_flag;
          next_rdata[scpm_pkg::FEN_BIT]        = fast_osc_enable;
        end
        scpm_pkg::OFF_MODE_STATUS: next_rdata = {2'h0, mode};
        default:                   next_rdata = 8'h00;
      endcase
    end
  end

  // register control bits and read data
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      // select resets to undivided fast clock
      sys_clk_select        <= scpm_pkg::SEL_FAST;
      fast_osc_keep_in_halt <= 1'b0;
      slow_osc_keep_in_halt <= 1'b0;
      fast_osc_freq_select  <= scpm_pkg::FREQ_RST;
      fast_osc_enable       <= scpm_pkg::FEN_RST;
      RDATA                 <= 8'h00;
    end else begin
      sys_clk_select        <= next_sel;
      fast_osc_keep_in_halt <= next_fkeep;
      slow_osc_keep_in_halt <= next_skeep;
      fast_osc_freq_select  <= next_freq;
      fast_osc_enable       <= next_fen;
      RDATA                 <= next_rdata;
    end
  end

  assign cpu_run = (mode == scpm_pkg::M_FAST) || (mode == scpm_pkg::M_SLOW);

  // fast oscillator run decision, settling count and frequency latch
  always_comb begin
    // running on sub clock the fast oscillator follows its enable bit, halted it follows its keep bit
    if (cpu_run) begin
      fast_run = fast_osc_enable || active_sel != scpm_pkg::SEL_SUB
                 || sys_clk_select != scpm_pkg::SEL_SUB;
    end else begin
      fast_run = fast_osc_keep_in_halt;
    end
    next_stable   = fast_osc_stable_flag;
    next_scnt     = scnt;
    next_act_freq = act_freq;
    // flag clears while off, sets after settling
    if (!fast_run) begin
      next_stable = 1'b0;
      next_scnt   = '0;
    end else if (fast_osc_stable_flag && fast_osc_freq_select != act_freq) begin
      next_stable = 1'b0;
      next_scnt   = '0;
    end else if (!fast_osc_stable_flag) begin
      if (scnt == SW'(FAST_STARTUP - 1)) begin
        // new frequency applies as the flag sets
        next_stable   = 1'b1;
        next_act_freq = fast_osc_freq_select;
      end else begin
        next_scnt = scnt + SW'(1);
      end
    end
  end

  // register fast oscillator state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fast_osc_stable_flag <= 1'b0;
      scnt                 <= '0;
      act_freq             <= scpm_pkg::FREQ_RST;
    end else begin
      fast_osc_stable_flag <= next_stable;
      scnt                 <= next_scnt;
      act_freq             <= next_act_freq;
    end
  end

  // fast oscillator, ticking only once settled
  scpm_tick_gen #(.W(PW)) u_fast_osc (
    .clk    (CLK),
    .rst_n  (RST_N),
    .run    (fast_osc_stable_flag),
    .period (fast_period(act_freq)),
    .tick   (fast_tick)
  );

  scpm_tick_gen #(.W(PW)) u_slow_osc (
    .clk    (CLK),
    .rst_n  (RST_N),
    .run    (1'b1),
    .period (PW'(SLOW_PERIOD)),
    .tick   (slow_tick)
  );

  // divided clock and glitch-free source swap
  always_comb begin
    div_tick = fast_tick && ((div_cnt & div_mask(active_sel)) == div_mask(active_sel));
    // code 111 selects the sub clock
    cur_tick = (active_sel == scpm_pkg::SEL_SUB) ? slow_tick : div_tick;
    // swap on a period boundary, target must be running
    swap = (sys_clk_select != active_sel)
           && (sys_clk_select == scpm_pkg::SEL_SUB || fast_osc_stable_flag)
           && (cur_tick || (active_sel != scpm_pkg::SEL_SUB && !fast_osc_stable_flag));
    next_active_sel = active_sel;
    next_div_cnt    = div_cnt;
    // source follows the select field without reset
    if (swap) begin
      next_active_sel = sys_clk_select;
      next_div_cnt    = 6'h00;
    end else if (fast_tick) begin
      next_div_cnt = div_cnt + 6'h01;
    end
  end

  // register switch state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      active_sel <= scpm_pkg::SEL_FAST;
      div_cnt    <= 6'h00;
    end else begin
      active_sel <= next_active_sel;
      div_cnt    <= next_div_cnt;
    end
  end

  // operating mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      scpm_pkg::M_FAST, scpm_pkg::M_SLOW: begin
        if (HALT) begin
          unique case ({fast_osc_keep_in_halt, slow_osc_keep_in_halt})
            2'b00: next_mode = scpm_pkg::M_SLEEP;
            2'b01: next_mode = scpm_pkg::M_IDLE0;
            2'b10: next_mode = scpm_pkg::M_IDLE2;
            default: next_mode = scpm_pkg::M_IDLE1;
          endcase
        end else if (next_active_sel == scpm_pkg::SEL_SUB) begin
          next_mode = scpm_pkg::M_SLOW;
        end else begin
          next_mode = scpm_pkg::M_FAST;
        end
      end
      scpm_pkg::M_SLEEP, scpm_pkg::M_IDLE0, scpm_pkg::M_IDLE1, scpm_pkg::M_IDLE2: begin
        if (WAKE) begin
          next_mode = (active_sel == scpm_pkg::SEL_SUB) ? scpm_pkg::M_SLOW : scpm_pkg::M_FAST;
        end
      end
      default: next_mode = scpm_pkg::M_FAST;
    endcase
  end

  // gate clock enables by mode
  always_comb begin
    // halted system clock per mode and source
    unique case (mode)
      scpm_pkg::M_SLEEP: next_sys_en = 1'b0;
      scpm_pkg::M_IDLE0: next_sys_en = cur_tick && active_sel == scpm_pkg::SEL_SUB;
      scpm_pkg::M_IDLE2: next_sys_en = cur_tick && active_sel != scpm_pkg::SEL_SUB;
      default:           next_sys_en = cur_tick;
    endcase
    // sub clock to peripherals off in sleep and idle2
    next_sub_en = slow_tick && mode != scpm_pkg::M_SLEEP && mode != scpm_pkg::M_IDLE2;
  end

  // register mode and all clock outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode        <= scpm_pkg::M_FAST;
      SYS_CLK_EN  <= 1'b0;
      FAST_CLK_EN <= 1'b0;
      SUB_CLK_EN  <= 1'b0;
      SLOW_RC_CLK_EN <= 1'b0;
      CPU_RUN     <= 1'b1;
      FAST_OSC_ON <= 1'b0;
    end else begin
      mode        <= next_mode;
      SYS_CLK_EN  <= next_sys_en;
      FAST_CLK_EN <= fast_tick;
      SUB_CLK_EN  <= next_sub_en;
      SLOW_RC_CLK_EN <= slow_tick;
      CPU_RUN     <= next_mode == scpm_pkg::M_FAST || next_mode == scpm_pkg::M_SLOW;
      FAST_OSC_ON <= fast_run;
    end
  end

  // checks: a halt taken while running, and the keep bits beside it
  sequence s_halt;
    HALT && cpu_run;
  endsequence

  sequence s_keep(f, s);
    fast_osc_keep_in_halt == f && slow_osc_keep_in_halt == s;
  endsequence

  a_sleep_entry: assert property ((s_halt and s_keep(1'b0, 1'b0))
    |=> mode == scpm_pkg::M_SLEEP ##1 !SUB_CLK_EN)
    else $error("halt with no keep bits did not sleep");
  a_idle0_entry: assert property ((s_halt and s_keep(1'b0, 1'b1))
    |=> mode == scpm_pkg::M_IDLE0)
    else $error("idle0 not entered");
  a_idle1_entry: assert property ((s_halt and s_keep(1'b1, 1'b1))
    |=> mode == scpm_pkg::M_IDLE1 ##1 fast_run)
    else $error("idle1 not entered");
  a_idle2_entry: assert property ((s_halt and s_keep(1'b1, 1'b0))
    |=> mode == scpm_pkg::M_IDLE2 ##1 !SUB_CLK_EN)
    else $error("idle2 not entered");
  a_sleep_slow_rc_osc: assert property (mode == scpm_pkg::M_SLEEP && slow_tick
    |=> SLOW_RC_CLK_EN && !SUB_CLK_EN && !SYS_CLK_EN)
    else $error("slow oscillator stopped in sleep");
  a_stable_gate: assert property (!fast_osc_stable_flag && !$past(fast_osc_stable_flag)
    |-> !fast_tick)
    else $error("fast clock used before stable");
  a_settle_time: assert property ($rose(fast_osc_stable_flag)
    |-> $past(scnt) == SW'(FAST_STARTUP - 1) && $past(fast_run))
    else $error("stable flag set early");
  a_swap_taken: assert property (sys_clk_select == scpm_pkg::SEL_SUB
    && active_sel != scpm_pkg::SEL_SUB && (cur_tick || !fast_osc_stable_flag)
    |=> active_sel == scpm_pkg::SEL_SUB)
    else $error("switch to sub clock not taken");
  a_slow_source: assert property (mode == scpm_pkg::M_SLOW
    |-> $past(next_active_sel) == scpm_pkg::SEL_SUB)
    else $error("slow mode without sub clock");
endmodule

// ### system_clock_and_power_modes_test.sv
// system_clock_and_power_modes_test: self-checking bench of scpm_top.
// assumes shortened slow period and start-up counts, bench drives every port.
module system_clock_and_power_modes_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = 20;
  localparam int ST = 8;
  // design ports
  logic       CLK;
  logic       RST_N;
  logic [3:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       HALT;
  logic       WAKE;
  logic       SYS_CLK_EN;
  logic       FAST_CLK_EN;
  logic       SUB_CLK_EN;
  logic       SLOW_RC_CLK_EN;
  logic       CPU_RUN;
  logic       FAST_OSC_ON;
  // bench state
  int         n_errors;
  int         samples_checked;
  logic [7:0] rd;
  int         gap;
  int         cnt [4];

  scpm_top #(.SLOW_PERIOD(SP), .FAST_STARTUP(ST)) DUT (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .HALT(HALT), .WAKE(WAKE), .SYS_CLK_EN(SYS_CLK_EN),
    .FAST_CLK_EN(FAST_CLK_EN), .SUB_CLK_EN(SUB_CLK_EN), .SLOW_RC_CLK_EN(SLOW_RC_CLK_EN),
    .CPU_RUN(CPU_RUN), .FAST_OSC_ON(FAST_OSC_ON)
  );

  // 250 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // compares one value and counts it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // prints counts and verdict, ends the run
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // one-cycle halt or wake pulse, settled after the taking edge
  task automatic pulse_cpu(input logic h);
    @(posedge CLK);
    if (h) begin
      HALT <= 1'b1;
    end else begin
      WAKE <= 1'b1;
    end
    @(posedge CLK);
    HALT <= 1'b0;
    WAKE <= 1'b0;
    #1;
  endtask

  // selects a tick output by number
  function automatic logic pick(input int s);
    case (s)
      0:       return SYS_CLK_EN;
      1:       return FAST_CLK_EN;
      2:       return SUB_CLK_EN;
      default: return SLOW_RC_CLK_EN;
    endcase
  endfunction

  // cycles between two ticks of one output, bounded wait
  task automatic measure(input int s, output int n);
    int k;
    k = 0;
    n = 0;
    @(posedge CLK);
    #1;
    while (pick(s) !== 1'b1 && k < 5000) begin
      @(posedge CLK);
      #1;
      k++;
    end
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (pick(s) !== 1'b1 && n < 5000);
  endtask

  // counts ticks of all four outputs over a window
  task automatic tally(input int len);
    cnt = '{0, 0, 0, 0};
    repeat (len) begin
      @(posedge CLK);
      #1;
      for (int i = 0; i < 4; i++) begin
        cnt[i] += int'(pick(i) === 1'b1);
      end
    end
  endtask

  // values after reset, settling flag, unmapped address
  task automatic t_reset;
    rdr(4'h4, rd);
    check(rd, 8'h01);
    check(CPU_RUN, 1'b1);
    rdr(4'h0, rd);
    check(rd, 8'h00);
    rdr(4'h8, rd);
    check(rd, 8'h01);
    repeat (20) @(posedge CLK);
    rdr(4'h4, rd);
    check(rd, 8'h03);
    wr(4'hC, 8'hFF);
    rdr(4'hC, rd);
    check(rd, 8'h00);
    rdr(4'h0, rd);
    check(rd, 8'h00);
  endtask

  // reserved and read-only bits ignored, code 11 kept
  task automatic t_fields;
    wr(4'h0, 8'h1F);
    rdr(4'h0, rd);
    check(rd, 8'h03);
    wr(4'h0, 8'h00);
    // code 11 with the read-only stable bit written as zero
    wr(4'h4, 8'hFD);
    repeat (30) @(posedge CLK);
    rdr(4'h4, rd);
    check(rd, 8'h0F);
  endtask

  // fast periods for every frequency code, undivided system clock
  task automatic t_freq;
    int per [4] = '{125, 62, 31, 125};
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {4'h0, c[1:0], 2'h1});
      repeat (30) @(posedge CLK);
      measure(1, gap);
      measure(1, gap);
      check(gap, per[c]);
      measure(0, gap);
      measure(0, gap);
      check(gap, per[c]);
    end
  endtask

  // every divide code at 8 MHz
  task automatic t_div;
    wr(4'h4, 8'h09);
    for (int s = 1; s < 7; s++) begin
      wr(4'h0, {s[2:0], 5'h00});
      measure(0, gap);
      measure(0, gap);
      check(gap, 31 << s);
    end
  endtask

  // run-time swap to sub clock, fast oscillator off and on again
  task automatic t_slow;
    wr(4'h0, 8'hE0);
    // the swap waits for the end of the running divide-by-64 period
    repeat (2100) @(posedge CLK);
    rdr(4'h8, rd);
    check(rd, 8'h02);
    measure(0, gap);
    check(gap, SP);
    measure(3, gap);
    check(gap, SP);
    check(FAST_OSC_ON, 1'b1);
    measure(1, gap);
    check(gap, 31);
    wr(4'h4, 8'h08);
    repeat (10) @(posedge CLK);
    check(FAST_OSC_ON, 1'b0);
    tally(100);
    check(cnt[1], 0);
    check(cnt[0], 100 / SP);
    wr(4'h4, 8'h09);
    rdr(4'h4, rd);
    check(rd, 8'h09);
    repeat (30) @(posedge CLK);
    rdr(4'h4, rd);
    check(rd, 8'h0B);
    wr(4'h0, 8'h00);
    repeat (60) @(posedge CLK);
    rdr(4'h8, rd);
    check(rd, 8'h01);
  endtask

  // every keep-bit pair from both sources, halt and wake
  task automatic t_halt;
    logic [1:0] k;
    logic       sub;
    logic [7:0] md;
    for (int m = 0; m < 8; m++) begin
      k = m[1:0];
      sub = m[2];
      md = (k == 2'h0) ? 8'h04 : (k == 2'h1) ? 8'h08 : (k == 2'h3) ? 8'h10 : 8'h20;
      wr(4'h4, 8'h09);
      wr(4'h0, {sub ? 3'h7 : 3'h0, 3'h0, k});
      repeat (80) @(posedge CLK);
      pulse_cpu(1'b1);
      check(CPU_RUN, 1'b0);
      rdr(4'h8, rd);
      check(rd, md);
      pulse_cpu(1'b1);
      repeat (8) @(posedge CLK);
      tally(200);
      check(cnt[0] > 0, k == 2'h3 || (k == 2'h1 && sub) || (k == 2'h2 && !sub));
      check(cnt[2] > 0, k[0]);
      check(cnt[1] > 0, k[1]);
      check(cnt[3], 200 / SP);
      check(FAST_OSC_ON, k[1]);
      rdr(4'h8, rd);
      check(rd, md);
      pulse_cpu(1'b0);
      check(CPU_RUN, 1'b1);
      pulse_cpu(1'b0);
      rdr(4'h8, rd);
      check(rd, sub ? 8'h02 : 8'h01);
    end
  endtask

  // main sequence
  initial begin
    RST_N = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    HALT = 1'b0;
    WAKE = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset;
    t_fields;
    t_freq;
    t_div;
    t_slow;
    t_halt;
    complete_run;
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge CLK);
    n_errors++;
    complete_run;
  end
endmodule
